// [core/pwm_freq_pkg.sv]
// Shared constants and carrier types for the PWM switching-frequency block.
// Assumes a single 100 MHz pclk domain and an APB register slave.
package pwm_freq_pkg;

  // ----------------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------------
  localparam int NUM_CH = 4;
  localparam logic [7:0] ADDR_SW_FREQ = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_DUTY_BASE = 8'h10;
  localparam logic [7:0] ADDR_CEIL_BASE = 8'h20;
  localparam int OSC_LSB = 4;
  localparam int DIV_LSB = 0;
  localparam logic [7:0] SW_FREQ_RESET = 8'h01;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  localparam logic [7:0] CEIL_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Oscillator synthesis and timing
  // ----------------------------------------------------------------------
  // Oscillator rate is (15 - code) * 3.2 MHz; against 100 MHz that is an
  // accumulator step of 4 * (15 - code) out of a modulus of 125.
  localparam logic [7:0] OSC_MOD = 8'h7D;
  localparam logic [3:0] OSC_STEP_BASE = 4'hF;
  localparam logic [7:0] PERIOD_UNIT = 8'h10;
  localparam logic [7:0] SAMPLE_TICKS = 8'h10;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MIN_ON_NS = 40;
  localparam int MIN_ON_CYC = (MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] PCT_FULL = 8'h64;

  // Highest usable duty per divider code, in percent.
  function automatic logic [7:0] max_duty_pct(input logic [2:0] div);
    case (div)
      3'h1: max_duty_pct = 8'h2F;
      3'h2: max_duty_pct = 8'h40;
      3'h3: max_duty_pct = 8'h48;
      3'h4: max_duty_pct = 8'h4D;
      3'h5: max_duty_pct = 8'h50;
      3'h6: max_duty_pct = 8'h53;
      3'h7: max_duty_pct = 8'h55;
      default: max_duty_pct = 8'h00;
    endcase
  endfunction

  typedef struct packed {
    logic tick;
    logic start;
    logic [6:0] cnt;
  } timebase_t;

endpackage

// [core/pwm_phase_driver.sv]
// One PWM channel: compares the shared period count with its on-time and
// drives complementary high and low side gate commands.
// Assumes the timebase and on-time come from the same pclk domain.
module pwm_phase_driver
  import pwm_freq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire timebase_t tb,
  input wire logic [7:0] on_ticks,
  output logic high_side,
  output logic low_side
);

  typedef struct packed {
    logic high;
    logic low;
    logic [2:0] hold;
    logic [7:0] on_latch;
  } drv_state_t;

  drv_state_t s;
  drv_state_t next_s;
  logic [7:0] on_sel;
  logic want;

  always_comb begin
    next_s = s;
    on_sel = tb.start ? on_ticks : s.on_latch;
    want = ({1'b0, tb.cnt} < on_sel);
    if (!run) begin
      next_s.high = 1'b0;
      next_s.low = 1'b0;
      next_s.hold = 3'h0;
      next_s.on_latch = 8'h00;
    end else begin
      if (tb.start) begin
        next_s.on_latch = on_ticks;
      end
      // A pulse once started is held for the full minimum on-time, even if
      // the compare has already dropped, so short duties never produce runts.
      if (s.high && (s.hold < 3'(MIN_ON_CYC - 1))) begin
        next_s.high = 1'b1;
        next_s.hold = s.hold + 3'h1;
      end else begin
        next_s.high = want;
        if (!s.high && want) begin
          next_s.hold = 3'h0;
        end
      end
      next_s.low = !next_s.high;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign high_side = s.high;
  assign low_side = s.low;

  AST_MIN_ON: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s.high) |-> s.high [*4])
    else $error("High side pulse shorter than the minimum on-time.");

  AST_NO_SHOOT: assert property (@(posedge pclk) disable iff (!presetn)
    !(s.high && s.low))
    else $error("High and low side driven together.");

endmodule

// [core/pwm_switching_frequency_duty_limit.sv]
// Switching-frequency timebase, duty clamping and APB registers for four
// buck PWM channels.
// Assumes an APB master on pclk/presetn and external gate drivers that
// treat high_side and low_side as active-high switch commands.
//
// The implementer's own choices: the APB register port and the register addresses.
import pwm_freq_pkg::*;

// How it works
// - Bits [6:4] of the frequency register pick one of eight oscillator rates from 48 MHz at 000 down in equal steps to 25.6 MHz at 111.
// - Bits [2:0] of the frequency register pick the divider, and divider code 000 is invalid.
// - The switching frequency follows from both codes, from 1.5 MHz at 000/001 down to 300 kHz, and settings below that are refused.
// - Every high side pulse that starts lasts at least 40 ns unless its channel is disabled or its setting turns invalid mid-pulse.
// - Each period but the first after a frequency write leaves the low side on for at least sixteen oscillator cycles so current can be sampled.
// - A channel whose duty reaches its programmed ceiling is clamped there.
// - The usable duty is capped per divider code, from 47 percent at 001 to 85 percent at 111.
module pwm_switching_frequency_duty_limit
  import pwm_freq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [NUM_CH-1:0] high_side,
  output logic [NUM_CH-1:0] low_side
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] sw_freq;
    logic [NUM_CH-1:0] enable;
    logic [NUM_CH-1:0][7:0] duty;
    logic [NUM_CH-1:0][7:0] ceiling;
    logic [7:0] acc;
    timebase_t tb;
    logic [31:0] rdata;
    logic err;
  } core_state_t;

  core_state_t s;
  core_state_t next_s;

  logic [2:0] osc_code;
  logic [2:0] div_code;
  logic [7:0] osc_step;
  logic [7:0] acc_sum;
  logic [7:0] period;
  logic [7:0] pct_cap;
  logic cfg_valid;
  logic [NUM_CH-1:0] run;
  logic [NUM_CH-1:0] clamped;
  logic [NUM_CH-1:0][7:0] on_ticks;
  logic [NUM_CH-1:0][7:0] max_on;
  logic [NUM_CH-1:0][7:0] on_req;
  logic wr_en;
  logic setup;
  logic [7:0] idx_off;

  // ----------------------------------------------------------------------
  // Frequency decode and duty limits
  // ----------------------------------------------------------------------
  always_comb begin
    osc_code = s.sw_freq[OSC_LSB +: 3];
    div_code = s.sw_freq[DIV_LSB +: 3];
    osc_step = {2'b00, (OSC_STEP_BASE - {1'b0, osc_code}), 2'b00};
    acc_sum = s.acc + osc_step;
    period = PERIOD_UNIT * ({5'h00, div_code} + 8'h01);
    pct_cap = max_duty_pct(div_code);
    // Fosc >= 16 * (div + 1) * 300 kHz, written in 1.6 MHz units.
    cfg_valid = (div_code != 3'h0) &&
      ({1'b0, OSC_STEP_BASE - {1'b0, osc_code}, 1'b0} >=
       5'(3 * ({2'b00, div_code} + 5'h01)));
    for (int ch = 0; ch < NUM_CH; ch++) begin
      run[ch] = s.enable[ch] && cfg_valid;
      max_on[ch] = 8'((16'(period) * 16'(pct_cap)) / 16'(PCT_FULL));
      // Duty codes are fractions of 256; the ceiling wins over the command.
      on_req[ch] = 8'((16'(period) * 16'((s.duty[ch] > s.ceiling[ch]) ?
        s.ceiling[ch] : s.duty[ch])) >> 8);
      on_ticks[ch] = (on_req[ch] > max_on[ch]) ? max_on[ch] : on_req[ch];
      clamped[ch] = run[ch] && ((s.duty[ch] > s.ceiling[ch]) ||
        (on_req[ch] > max_on[ch]));
    end
  end

  // ----------------------------------------------------------------------
  // Timebase and APB slave
  // ----------------------------------------------------------------------
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign idx_off = {4'h0, paddr[3:0]};

  always_comb begin
    next_s = s;
    next_s.tb.tick = 1'b0;
    next_s.tb.start = 1'b0;
    if (!cfg_valid) begin
      next_s.acc = 8'h00;
      next_s.tb.cnt = 7'h00;
    end else begin
      if (acc_sum >= OSC_MOD) begin
        next_s.acc = acc_sum - OSC_MOD;
        next_s.tb.tick = 1'b1;
        if ({1'b0, s.tb.cnt} == period - 8'h01) begin
          next_s.tb.cnt = 7'h00;
          next_s.tb.start = 1'b1;
        end else begin
          next_s.tb.cnt = s.tb.cnt + 7'h01;
        end
      end else begin
        next_s.acc = acc_sum;
      end
    end
    // Read data is captured in the setup cycle so it is stable in access.
    if (setup) begin
      next_s.err = 1'b0;
      next_s.rdata = 32'h0000_0000;
      if (paddr == ADDR_SW_FREQ) begin
        next_s.rdata = {24'h00_0000, s.sw_freq};
      end else if (paddr == ADDR_CTRL) begin
        next_s.rdata = {28'h000_0000, s.enable};
      end else if (paddr == ADDR_STATUS) begin
        next_s.rdata = {20'h0_0000, clamped, high_side, 3'h0, cfg_valid};
      end else if ((paddr[7:4] == ADDR_DUTY_BASE[7:4]) && (paddr[1:0] == 2'h0)
          && ({1'b0, idx_off[3:2]} < 3'(NUM_CH))) begin
        next_s.rdata = {24'h00_0000, s.duty[idx_off[3:2]]};
      end else if ((paddr[7:4] == ADDR_CEIL_BASE[7:4]) && (paddr[1:0] == 2'h0)
          && ({1'b0, idx_off[3:2]} < 3'(NUM_CH))) begin
        next_s.rdata = {24'h00_0000, s.ceiling[idx_off[3:2]]};
      end else begin
        next_s.err = 1'b1;
      end
    end
    if (wr_en && !s.err) begin
      if (paddr == ADDR_SW_FREQ) begin
        next_s.sw_freq = {1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
        // A new setting restarts the period so no stretched cycle appears.
        next_s.acc = 8'h00;
        next_s.tb.cnt = 7'h00;
        next_s.tb.tick = 1'b0;
        next_s.tb.start = 1'b0;
      end else if (paddr == ADDR_CTRL) begin
        next_s.enable = pwdata[NUM_CH-1:0];
      end else if (paddr[7:4] == ADDR_DUTY_BASE[7:4]) begin
        next_s.duty[idx_off[3:2]] = pwdata[7:0];
      end else if (paddr[7:4] == ADDR_CEIL_BASE[7:4]) begin
        next_s.ceiling[idx_off[3:2]] = pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.sw_freq <= SW_FREQ_RESET;
      s.duty <= {NUM_CH{DUTY_RESET}};
      s.ceiling <= {NUM_CH{CEIL_RESET}};
    end else begin
      s <= next_s;
    end
  end

  assign pready = 1'b1;
  assign prdata = s.rdata;
  assign pslverr = psel && penable && s.err;

  // ----------------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------------
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    pwm_phase_driver u_drv (
      .pclk(pclk),
      .presetn(presetn),
      .run(run[ch]),
      .tb(s.tb),
      .on_ticks(on_ticks[ch]),
      .high_side(high_side[ch]),
      .low_side(low_side[ch])
    );
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  AST_ACC_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
    s.tb.tick |-> ##1 !s.tb.tick || ($past(s.acc) >= 8'h3E))
    else $error("Oscillator ticks arrive faster than 48 MHz allows.");

  AST_DIV_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (div_code == 3'h0) |-> !cfg_valid ##1 (high_side == '0) && (low_side == '0))
    else $error("Divider code zero still drives outputs.");

  AST_NA_CFG: assert property (@(posedge pclk) disable iff (!presetn)
    (osc_code == 3'h7 && div_code == 3'h5) |-> !cfg_valid)
    else $error("Setting below 300 kHz accepted.");

  AST_SAMPLE_ROOM: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_valid |-> (on_ticks[0] <= period - SAMPLE_TICKS))
    else $error("On-time leaves under sixteen oscillator cycles for sampling.");

  AST_CEILING: assert property (@(posedge pclk) disable iff (!presetn)
    (s.duty[0] > s.ceiling[0]) |->
      (on_ticks[0] <= 8'((16'(period) * 16'(s.ceiling[0])) >> 8)))
    else $error("Duty ceiling exceeded.");

  AST_DIV_CAP: assert property (@(posedge pclk) disable iff (!presetn)
    (div_code == 3'h1 && s.duty[0] == 8'hFF && s.ceiling[0] == 8'hFF)
      |-> (on_ticks[0] == 8'h0F))
    else $error("Divider one does not cap at 47 percent.");

  AST_PERIOD_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
    s.tb.start |-> (s.tb.cnt == 7'h00) && ($past(s.tb.cnt) == 7'(period - 8'h01)))
    else $error("Period counter wrapped at the wrong count.");

  AST_PERIOD_BOUND: assert property (@(posedge pclk) disable iff (!presetn)
    ({1'b0, s.tb.cnt} < period))
    else $error("Period counter ran past the period length.");

  COV_PULSE: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(high_side[0]));
  COV_CLAMP: cover property (@(posedge pclk) disable iff (!presetn)
    clamped[2]);
  COV_INVALID: cover property (@(posedge pclk) disable iff (!presetn)
    s.enable[0] && !cfg_valid);
  COV_WRAP: cover property (@(posedge pclk) disable iff (!presetn)
    s.tb.start && div_code == 3'h7);

endmodule

// [tb/gate_driver_model.sv]
// Stand-in for the external switch drivers; measures channel 0 pulses.
// Assumes high_side and low_side are registered levels on pclk.
module gate_driver_model
  import pwm_freq_pkg::*;
(
  input wire logic pclk,
  input wire logic [NUM_CH-1:0] high_side,
  input wire logic [NUM_CH-1:0] low_side,
  output int hi_w,
  output int lo_w,
  output int per,
  output logic overlap
);
  timeunit 1ns;
  timeprecision 1ns;
  int hc = 0;
  int lc = 0;
  int pc = 0;
  logic hp = 1'b0;
  logic ov = 1'b0;
  assign overlap = ov;
  // A driver would short the supply if both switches were on at once.
  always @(posedge pclk) begin
    if (high_side[0] && low_side[0]) ov <= 1'b1;
    if (high_side[0]) hc <= hc + 1;
    else begin
      if (hc != 0) hi_w <= hc;
      hc <= 0;
    end
    if (low_side[0]) lc <= lc + 1;
    else begin
      if (lc != 0) lo_w <= lc;
      lc <= 0;
    end
    if (high_side[0] && !hp) begin
      per <= pc;
      pc <= 1;
    end else pc <= pc + 1;
    hp <= high_side[0];
  end
endmodule

// [tb/tb_pwm_switching_frequency_duty_limit.sv]
// Self-checking bench for the switching-frequency and duty-limit block.
// Assumes a zero-wait APB slave and measures channel 0 at the driver model.
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb_pwm_switching_frequency_duty_limit
  import pwm_freq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [NUM_CH-1:0] high_side;
  logic [NUM_CH-1:0] low_side;
  int hi_w;
  int lo_w;
  int per;
  logic overlap;
  int fail_count = 0;
  int n_tests = 0;
  logic [31:0] q;
  logic err;

  pwm_switching_frequency_duty_limit u_pwm_switching_frequency_duty_limit (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .high_side(high_side), .low_side(low_side));
  gate_driver_model u_gate_driver_model (
    .pclk(pclk), .high_side(high_side), .low_side(low_side),
    .hi_w(hi_w), .lo_w(lo_w), .per(per), .overlap(overlap));

  initial begin
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------------
  // APB master
  // ----------------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    `CHK("read", e, q)
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs();
    rd_chk(ADDR_SW_FREQ, 32'h0000_0001);
    rd_chk(ADDR_CEIL_BASE, 32'h0000_0000);
    xfer(1'b1, ADDR_SW_FREQ, 32'h0000_00FF);
    rd_chk(ADDR_SW_FREQ, 32'h0000_0077);
    xfer(1'b1, 8'h3C, 32'h0000_00AA);
    `CHK("pslverr", 1'b1, err)
    rd_chk(8'h3C, 32'h0000_0000);
  endtask

  task automatic t_valid();
    xfer(1'b1, ADDR_SW_FREQ, 32'h0000_0000);
    rd_chk(ADDR_STATUS, 32'h0000_0000);
    xfer(1'b1, ADDR_SW_FREQ, 32'h0000_0075);
    rd_chk(ADDR_STATUS, 32'h0000_0000);
    xfer(1'b1, ADDR_SW_FREQ, 32'h0000_0065);
    rd_chk(ADDR_STATUS, 32'h0000_0001);
  endtask

  task automatic t_clamp();
    xfer(1'b1, ADDR_SW_FREQ, 32'h0000_0001);
    xfer(1'b1, ADDR_DUTY_BASE, 32'h0000_0080);
    xfer(1'b1, ADDR_CEIL_BASE, 32'h0000_00FF);
    xfer(1'b1, ADDR_CTRL, 32'h0000_0001);
    repeat (400) @(posedge pclk);
    `CHK("hi_w15", 1'b1, hi_w >= 31 && hi_w <= 32)
    `CHK("lo_w", 1'b1, lo_w >= 33)
    `CHK("overlap", 1'b0, overlap)
    xfer(1'b0, ADDR_STATUS, 32'h0000_0000);
    `CHK("clamped", 1'b1, q[8])
    xfer(1'b1, ADDR_CEIL_BASE, 32'h0000_0040);
    repeat (400) @(posedge pclk);
    `CHK("hi_w8", 1'b1, hi_w >= 16 && hi_w <= 17)
  endtask

  task automatic t_period();
    // A full command at divider 1 must stop at the 47 percent cap.
    xfer(1'b1, ADDR_CEIL_BASE, 32'h0000_00FF);
    xfer(1'b1, ADDR_DUTY_BASE, 32'h0000_00FF);
    repeat (400) @(posedge pclk);
    `CHK("hi_w47", 1'b1, hi_w >= 31 && hi_w <= 32)
    // Ceiling follows the 64 percent limit of divider 2.
    xfer(1'b1, ADDR_CEIL_BASE, 32'h0000_00A3);
    xfer(1'b1, ADDR_DUTY_BASE, 32'h0000_00FF);
    xfer(1'b1, ADDR_SW_FREQ, 32'h0000_0002);
    repeat (500) @(posedge pclk);
    `CHK("per_d2", 100, per)
    `CHK("hi_w30", 1'b1, hi_w >= 62 && hi_w <= 63)
    // A 32 MHz external reference would pick oscillator code 5, well inside 5 percent.
    xfer(1'b1, ADDR_SW_FREQ, 32'h0000_0051);
    repeat (500) @(posedge pclk);
    `CHK("per_o5", 100, per)
  endtask

  task automatic t_minon();
    xfer(1'b1, ADDR_CEIL_BASE, 32'h0000_00FF);
    xfer(1'b1, ADDR_DUTY_BASE, 32'h0000_0003);
    xfer(1'b1, ADDR_SW_FREQ, 32'h0000_0007);
    repeat (900) @(posedge pclk);
    `CHK("hi_min", 1'b1, hi_w >= MIN_ON_CYC && hi_w <= 5)
    `CHK("per_d7", 1'b1, per >= 266 && per <= 267)
  endtask

  task automatic print_verdict();
    if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("hs_rst", 4'h0, high_side)
    t_regs();
    t_valid();
    t_clamp();
    t_period();
    t_minon();
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    print_verdict();
  end
endmodule
